// File: verilog/sss_pkg.sv
// Shared constants and types for the SPI slave-select synchronised port.
// Assumes both ends run on one 100 MHz system clock with async active-low reset.
package sss_pkg;
    // Mode field of port_control_one, bits 3..0
    localparam logic [3:0] MODE_SLAVE_SELECT = 4'h4;
    localparam logic [3:0] MODE_SLAVE_FREE = 4'h5;
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 3;
    // Bit positions inside the controller's own APB registers
    localparam int CTRL_START = 0;
    localparam int CTRL_POLARITY = 1;
    // Register offsets of the controller (byte addresses)
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_TXDATA = 8'h04;
    localparam logic [7:0] OFF_RXDATA = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_MASK = 8'h10;
    localparam logic [7:0] OFF_DIVIDE = 8'h14;
    // Values after reset, plus LAST_BIT, the index of a byte's final bit
    localparam logic [7:0] DIVIDE_RESET = 8'h08;
    localparam logic [2:0] BIT_COUNT_RESET = 3'h0;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [3:0] MODE_RESET = 4'h0;
    // Controller sequencing states
    typedef enum logic [2:0] {SSS_IDLE, SSS_SELECT, SSS_LOW, SSS_HIGH, SSS_DONE} sss_ctl_state_t;
endpackage : sss_pkg

// File: verilog/sss_link_if.sv
// Link between the SPI master controller and the slave port.
// The bench resolves the slave data wire from its enable; no pull resistor modelled.
`timescale 1ns/1ps
interface sss_link_if;
    logic serialClock; // Serial clock from the master
    logic slaveSelectN; // Slave select, active low
    logic masterOut; // Data from master to slave
    logic slaveOut; // Slave data output value
    logic slaveOutEn; // High while the slave drives its data pin
    logic slaveIn; // Resolved slave data as seen by the master
    modport slave (input serialClock, input slaveSelectN, input masterOut,
        output slaveOut, output slaveOutEn);
    modport master (output serialClock, output slaveSelectN, output masterOut,
        input slaveIn);
endinterface : sss_link_if

// File: verilog/sss_slave_port.sv
// SPI slave port with slave-select synchronisation, buffer overwrite and sleep operation.
// Assumes link pins are asynchronous to clock; mode 0 sampling on the leading edge.
// Function
// [R1] Shift on external clock, flag byte end
// [R2] Master idles clock before port enable
// [R3] Keeps shifting and interrupting while asleep
// [R4] Overwrite enable keeps newest unread byte
// [R5] Master holds select high until ready
// [R6] Mode 0100 selects select-controlled slave
// [R7] Select low enables transfer, drives output
// [R8] Select high floats output at once
// [R9] Select high resets port, drops partial byte
// [R10] Port reset clears bit counter
// [R11] Edge-select slave needs select control
// [R12] Sample-phase bit stays clear in slave
// [R13] Synchronise clock and select before use
`timescale 1ns/1ps
module sss_slave_port (
    input wire logic clock, // System clock, 100 MHz
    input wire logic nrst, // Async reset, active low
    sss_link_if.slave link, // Serial link to the master
    input wire logic serialPortEnable, // serial_port_enable, clears to reset port
    input wire logic [3:0] portMode, // Mode field of port_control_one
    input wire logic bufferOverwriteEnable, // buffer_overwrite_enable
    input wire logic clockIdlePolarity, // clock_idle_polarity, idle level of clock
    input wire logic [7:0] txByte, // Byte to send next
    input wire logic txLoad, // Pulse: load txByte
    input wire logic rxRead, // Pulse: software read of buffer
    input wire logic flagClear, // Pulse: clear byte_complete_flag
    input wire logic sleeping, // Core asleep; port keeps running
    output logic [7:0] shiftDataBuffer, // Last accepted received byte
    output logic byteCompleteFlag, // Sticky byte-complete flag
    output logic overflow, // Byte lost, buffer full without overwrite
    output logic wakeRequest, // Wake from sleep on a byte
    output logic clockPinLevel // Synchronised clock pin level
);
    typedef struct packed {
        logic [1:0] sckSync;
        logic [1:0] ssSync;
        logic [1:0] mosiSync;
        logic sckLast;
        logic [2:0] bitCount;
        logic [7:0] shiftIn;
        logic [7:0] shiftOut;
        logic [7:0] txHold;
        logic [7:0] buffer;
        logic bufferFull;
        logic flag;
        logic overflow;
        logic outBit;
        logic outEn;
    } sss_slave_state_t;

    sss_slave_state_t state;
    sss_slave_state_t next_state;
    logic sck;
    logic selectHigh;
    logic leading;
    logic trailing;
    logic portReset;
    logic selectMode;
    logic active;

    // Only second-stage synchroniser bits feed logic
    assign sck = state.sckSync[1] ^ clockIdlePolarity; // R13
    assign selectHigh = state.ssSync[1]; // R13
    assign selectMode = (portMode == sss_pkg::MODE_SLAVE_SELECT); // R6
    assign portReset = !serialPortEnable || (selectMode && selectHigh); // R9 R10
    assign active = !portReset;
    assign leading = active && sck && !state.sckLast;
    assign trailing = active && !sck && state.sckLast;

    // Shift engine; runs regardless of sleep so a byte can wake the core
    always_comb begin
        next_state = state;
        next_state.sckSync = {state.sckSync[0], link.serialClock}; // R13
        next_state.ssSync = {state.ssSync[0], link.slaveSelectN}; // R13
        next_state.mosiSync = {state.mosiSync[0], link.masterOut};
        next_state.sckLast = sck;
        if (txLoad) begin
            next_state.txHold = txByte;
        end
        if (rxRead) begin
            next_state.bufferFull = 1'b0;
        end
        if (flagClear) begin
            next_state.flag = 1'b0;
        end
        if (portReset) begin
            next_state.bitCount = sss_pkg::BIT_COUNT_RESET; // R10
            next_state.shiftIn = sss_pkg::BYTE_RESET; // R9
            next_state.shiftOut = next_state.txHold;
            next_state.outBit = next_state.txHold[7];
        end else begin
            if (leading) begin // R1
                next_state.shiftIn = {state.shiftIn[6:0], state.mosiSync[1]};
                next_state.bitCount = state.bitCount + 3'h1;
                if (state.bitCount == sss_pkg::LAST_BIT) begin
                    // Set beats a same-cycle clear or read
                    next_state.flag = 1'b1; // R1 R3
                    if (!state.bufferFull || rxRead || bufferOverwriteEnable) begin // R4
                        next_state.buffer = {state.shiftIn[6:0], state.mosiSync[1]};
                        next_state.bufferFull = 1'b1;
                    end else begin
                        next_state.overflow = 1'b1;
                    end
                    next_state.shiftOut = next_state.txHold;
                end
            end
            if (trailing) begin
                next_state.outBit = (state.bitCount == sss_pkg::BIT_COUNT_RESET)
                    ? state.shiftOut[7] : state.shiftOut[7 - state.bitCount];
            end
        end
        // Drive only while selected or when select is not used; float at once on rise
        next_state.outEn = serialPortEnable && !(selectMode && selectHigh); // R7 R8
        if (selectMode && selectHigh) begin
            next_state.outEn = 1'b0; // R8
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= '0;
            // Select synchroniser starts at the idle level, so no false select follows reset
            state.ssSync <= 2'b11;
        end else begin
            state <= next_state;
        end
    end

    assign link.slaveOut = state.outBit;
    assign link.slaveOutEn = state.outEn; // R7 R8
    assign shiftDataBuffer = state.buffer;
    assign byteCompleteFlag = state.flag;
    assign overflow = state.overflow;
    assign wakeRequest = state.flag && sleeping; // R3
    assign clockPinLevel = state.sckSync[1]; // R2
endmodule : sss_slave_port

// File: verilog/sss_master_ctl.sv
// APB-controlled SPI master that drives clock and select towards the slave port.
// Assumes the slave uses select-controlled mode; divider gives the link clock.
`timescale 1ns/1ps
module sss_master_ctl (
    input wire logic clock, // System clock
    input wire logic nrst, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready, always high
    output logic pslverr, // APB error on unmapped address
    output logic irq, // Level interrupt
    sss_link_if.master link // Serial link to the slave
);
    typedef struct packed {
        sss_pkg::sss_ctl_state_t fsm;
        logic [1:0] inSync;
        logic polarity;
        logic [7:0] txData;
        logic [7:0] rxData;
        logic [7:0] divide;
        logic [7:0] count;
        logic [2:0] bitCount;
        logic [7:0] shift;
        logic status;
        logic mask;
        logic sck;
        logic ssN;
        logic mosi;
        logic [31:0] rdata;
        logic err;
    } sss_master_state_t;

    sss_master_state_t state;
    sss_master_state_t next_state;
    logic access;
    logic tick;

    assign access = psel && penable;
    assign tick = (state.count == state.divide);

    always_comb begin
        next_state = state;
        next_state.inSync = {state.inSync[0], link.slaveIn};
        next_state.count = tick ? 8'h00 : state.count + 8'h01;
        next_state.err = 1'b0;
        // Read word is captured in the setup cycle so it stands through the access edge
        if (psel) begin
            next_state.rdata = 32'h0;
            case (paddr)
                sss_pkg::OFF_CONTROL: next_state.rdata = {30'h0, state.polarity,
                    state.fsm != sss_pkg::SSS_IDLE};
                sss_pkg::OFF_TXDATA: next_state.rdata = {24'h0, state.txData};
                sss_pkg::OFF_RXDATA: next_state.rdata = {24'h0, state.rxData};
                sss_pkg::OFF_STATUS: next_state.rdata = {31'h0, state.status};
                sss_pkg::OFF_MASK: next_state.rdata = {31'h0, state.mask};
                sss_pkg::OFF_DIVIDE: next_state.rdata = {24'h0, state.divide};
                default: next_state.err = 1'b1;
            endcase
        end
        // Only a status bit that the reader saw is cleared; a later event survives
        if (access) begin
            if (!pwrite && paddr == sss_pkg::OFF_STATUS && state.rdata[0]) begin
                next_state.status = 1'b0;
            end
            if (pwrite) begin
                case (paddr)
                    sss_pkg::OFF_CONTROL: begin
                        next_state.polarity = pwdata[sss_pkg::CTRL_POLARITY];
                        if (pwdata[sss_pkg::CTRL_START] && state.fsm == sss_pkg::SSS_IDLE) begin
                            next_state.fsm = sss_pkg::SSS_SELECT; // R5
                            next_state.count = 8'h00;
                        end
                    end
                    sss_pkg::OFF_TXDATA: next_state.txData = pwdata[7:0];
                    sss_pkg::OFF_MASK: next_state.mask = pwdata[0];
                    sss_pkg::OFF_DIVIDE: next_state.divide = pwdata[7:0];
                    default: next_state.err = 1'b1;
                endcase
            end
        end
        if (state.fsm == sss_pkg::SSS_IDLE) begin
            next_state.sck = state.polarity; // R2
            next_state.ssN = 1'b1; // R5
        end
        if (tick) begin
            case (state.fsm)
                sss_pkg::SSS_IDLE: ;
                sss_pkg::SSS_SELECT: begin
                    next_state.ssN = 1'b0; // R5
                    next_state.shift = state.txData;
                    next_state.mosi = state.txData[7];
                    next_state.bitCount = sss_pkg::BIT_COUNT_RESET;
                    next_state.fsm = sss_pkg::SSS_LOW;
                end
                sss_pkg::SSS_LOW: begin
                    next_state.sck = !state.polarity;
                    next_state.shift = {state.shift[6:0], state.inSync[1]};
                    next_state.fsm = sss_pkg::SSS_HIGH;
                end
                sss_pkg::SSS_HIGH: begin
                    next_state.sck = state.polarity;
                    next_state.mosi = state.shift[7];
                    next_state.bitCount = state.bitCount + 3'h1;
                    next_state.fsm = (state.bitCount == sss_pkg::LAST_BIT)
                        ? sss_pkg::SSS_DONE : sss_pkg::SSS_LOW;
                end
                sss_pkg::SSS_DONE: begin
                    next_state.ssN = 1'b1; // R5
                    next_state.rxData = state.shift;
                    next_state.status = 1'b1;
                    next_state.fsm = sss_pkg::SSS_IDLE;
                end
                default: next_state.fsm = sss_pkg::SSS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= '0;
            state.divide <= sss_pkg::DIVIDE_RESET;
            state.ssN <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign prdata = state.rdata;
    assign pready = 1'b1;
    assign pslverr = access && (next_state.err);
    assign irq = state.status && state.mask;
    assign link.serialClock = state.sck;
    assign link.slaveSelectN = state.ssN;
    assign link.masterOut = state.mosi;
endmodule : sss_master_ctl

// File: tb/sss_asserts.sv
// Wire checks on the link joining the master controller to slave port 0.
// Assumes clock polarity 0 and the controller's reset divide value.
`timescale 1ns/1ps
module sss_asserts (
    input wire logic clock, // System clock
    input wire logic nrst, // Async reset, active low
    input wire logic serialClock, // Link clock
    input wire logic slaveSelectN, // Select, active low
    input wire logic masterOut, // Master data
    input wire logic slaveOut, // Slave data value
    input wire logic slaveOutEn, // Slave drive enable
    input wire logic slaveIn // Resolved slave data
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    logic [3:0] pulses;
    // Pulses per frame; a lost or extra pulse garbles that frame only, as deselect resets the slave's bit count
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) pulses <= 4'h0;
        else if (slaveSelectN) pulses <= 4'h0;
        else if ($rose(serialClock)) pulses <= pulses + 4'h1;
    end
    // Frame framing, drive window and link timing
    property p_frame_pulses; $rose(slaveSelectN) |-> pulses == 4'h8; endproperty
    a_frame_pulses: assert property (p_frame_pulses) else $error("frame pulse count wrong");
    property p_float; $rose(slaveSelectN) |-> ##[0:4] !slaveOutEn; endproperty
    a_float: assert property (p_float) else $error("output still driven after deselect");
    property p_drive; $fell(slaveSelectN) |-> ##[0:4] slaveOutEn; endproperty
    a_drive: assert property (p_drive) else $error("output not driven after select");
    property p_quiet; slaveSelectN && $past(slaveSelectN, 5) |-> !slaveOutEn; endproperty
    a_quiet: assert property (p_quiet) else $error("output driven while deselected");
    property p_clock_idle; slaveSelectN |-> !serialClock; endproperty
    a_clock_idle: assert property (p_clock_idle) else $error("link clock not idle");
    property p_high_phase; $rose(serialClock) |-> serialClock [*8]; endproperty
    a_high_phase: assert property (p_high_phase) else $error("clock high too short");
    property p_low_phase; $fell(serialClock) && !slaveSelectN |-> !serialClock [*8]; endproperty
    a_low_phase: assert property (p_low_phase) else $error("clock low too short");
    property p_setup; $rose(serialClock) |-> $stable(masterOut) && $stable(slaveOut); endproperty
    a_setup: assert property (p_setup) else $error("data moved on sampling edge");
endmodule : sss_asserts

// File: tb/spi_slave_select_sync_bench.sv
// Bench: controller and slave 0 joined by a link; slave 1 is driven by the bench itself.
// Assumes a 100 MHz clock; both slaves share their software-side inputs.
`timescale 1ns/1ps
module spi_slave_select_sync_bench;
    logic clock = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, txByte = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, irq, lastOut = 1'b0;
    logic portEn = 1'b1, overwrite = 1'b0, sleeping = 1'b0;
    logic txLoad = 1'b0, rxRead = 1'b0, flagClear = 1'b0;
    logic [7:0] rxBuf [2];
    logic flag [2], ovf [2], wake [2], pinLvl [2];
    int fail_count = 0, cmp_count = 0;
    sss_link_if lnk [2] ();
    always #5 clock = ~clock;
    // Released data line shows the flipped last value, never a stale match
    always @(posedge clock) if (lnk[0].slaveOutEn) lastOut <= lnk[0].slaveOut;
    assign lnk[0].slaveIn = lnk[0].slaveOutEn ? lnk[0].slaveOut : ~lastOut;
    assign lnk[1].slaveIn = lnk[1].slaveOutEn ? lnk[1].slaveOut : ~lnk[1].slaveOut;
    initial begin
        lnk[1].serialClock = 1'b0;
        lnk[1].slaveSelectN = 1'b1;
        lnk[1].masterOut = 1'b0;
    end
    sss_master_ctl sss_master_ctl_i (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .link(lnk[0].master));
    // Slave 0 faces the controller, slave 1 faces this bench
    // Mode tied to select control; no sample-phase or edge-select option exists
    for (genvar g = 0; g < 2; g++) begin : gSlave
        sss_slave_port sss_slave_port_i (.clock(clock), .nrst(nrst), .link(lnk[g].slave),
            .serialPortEnable(portEn), .portMode(sss_pkg::MODE_SLAVE_SELECT),
            .bufferOverwriteEnable(overwrite), .clockIdlePolarity(1'b0), .txByte(txByte),
            .txLoad(txLoad), .rxRead(rxRead), .flagClear(flagClear), .sleeping(sleeping),
            .shiftDataBuffer(rxBuf[g]), .byteCompleteFlag(flag[g]), .overflow(ovf[g]),
            .wakeRequest(wake[g]), .clockPinLevel(pinLvl[g]));
    end
    sss_asserts sss_asserts_i (.clock(clock), .nrst(nrst), .serialClock(lnk[0].serialClock),
        .slaveSelectN(lnk[0].slaveSelectN), .masterOut(lnk[0].masterOut),
        .slaveOut(lnk[0].slaveOut), .slaveOutEn(lnk[0].slaveOutEn), .slaveIn(lnk[0].slaveIn));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One APB transfer; read data and error are taken at the edge that sees pready high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask : wr
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        chk(what, rd, exp);
    endtask : rchk
    // Bench-side master on link 1: data set half a bit before the rising edge
    task automatic bits2(input logic [7:0] tx, input int n, output logic [7:0] rx);
        for (int i = 7; i > 7 - n; i--) begin
            lnk[1].masterOut <= tx[i];
            repeat (10) @(posedge clock);
            rx[i] = lnk[1].slaveIn;
            lnk[1].serialClock <= 1'b1;
            repeat (10) @(posedge clock);
            lnk[1].serialClock <= 1'b0;
        end
        repeat (10) @(posedge clock);
    endtask : bits2
    // One controller byte; the mask decides whether the level interrupt may rise
    task automatic send(input logic [7:0] tx, input logic masked);
        flagClear <= 1'b1;
        @(posedge clock);
        flagClear <= 1'b0;
        wr(sss_pkg::OFF_MASK, {31'h0, !masked});
        wr(sss_pkg::OFF_TXDATA, {24'h0, tx});
        wr(sss_pkg::OFF_CONTROL, 32'h1);
        for (int n = 0; n < 3000 && flag[0] !== 1'b1; n++) @(posedge clock);
        repeat (40) @(posedge clock);
        chk("irq", irq, !masked);
        rchk("status", sss_pkg::OFF_STATUS, 32'h1);
        @(posedge clock);
        chk("irq after read", irq, 32'h0);
    endtask : send
    task automatic t_reset;
        logic [31:0] rd;
        logic err;
        rchk("divide", sss_pkg::OFF_DIVIDE, {24'h0, sss_pkg::DIVIDE_RESET});
        rchk("status", sss_pkg::OFF_STATUS, 32'h0);
        chk("pin level", pinLvl[0], 32'h0);
        chk("idle drive", lnk[0].slaveOutEn, 32'h0);
        apb(1'b1, 8'h18, 32'h0, rd, err);
        chk("unmapped", err, 32'h1);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_byte;
        sleeping <= 1'b1;
        txByte <= 8'h5a;
        txLoad <= 1'b1;
        @(posedge clock);
        txLoad <= 1'b0;
        send(8'ha5, 1'b0);
        chk("buffer", rxBuf[0], 32'ha5);
        chk("wake", wake[0], 32'h1);
        rchk("master rx", sss_pkg::OFF_RXDATA, 32'h5a);
        rxRead <= 1'b1;
        @(posedge clock);
        rxRead <= 1'b0;
        sleeping <= 1'b0;
        $display("t_byte done");
    endtask : t_byte
    task automatic t_overwrite;
        overwrite <= 1'b1;
        send(8'h3c, 1'b1);
        send(8'hc3, 1'b0);
        chk("newest kept", rxBuf[0], 32'hc3);
        chk("no overflow", ovf[0], 32'h0);
        overwrite <= 1'b0;
        send(8'h0f, 1'b0);
        chk("old kept", rxBuf[0], 32'hc3);
        chk("overflow", ovf[0], 32'h1);
        $display("t_overwrite done");
    endtask : t_overwrite
    task automatic t_abort;
        logic [7:0] rx;
        lnk[1].slaveSelectN <= 1'b0;
        bits2(8'hff, 3, rx);
        lnk[1].slaveSelectN <= 1'b1;
        lnk[1].masterOut <= ~lnk[1].masterOut;
        txByte <= 8'h96;
        txLoad <= 1'b1;
        repeat (10) @(posedge clock);
        txLoad <= 1'b0;
        chk("float", lnk[1].slaveOutEn, 32'h0);
        chk("no flag", flag[1], 32'h0);
        lnk[1].slaveSelectN <= 1'b0;
        bits2(8'h69, 8, rx);
        chk("realigned", rxBuf[1], 32'h69);
        chk("msb first", rx, 32'h96);
        overwrite <= 1'b1;
        bits2(8'hff, 3, rx);
        portEn <= 1'b0;
        repeat (5) @(posedge clock);
        portEn <= 1'b1;
        bits2(8'h5c, 8, rx);
        lnk[1].slaveSelectN <= 1'b1;
        chk("count cleared", rxBuf[1], 32'h5c);
        $display("t_abort done");
    endtask : t_abort
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    // Hang guard, far beyond the roughly 1300 cycles the tests need
    initial begin
        repeat (30000) @(posedge clock);
        fail_count++;
        $display("ERROR watchdog expected done seen hang");
        report_and_stop();
    end
    initial begin
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        t_reset();
        t_byte();
        t_overwrite();
        t_abort();
        report_and_stop();
    end
endmodule : spi_slave_select_sync_bench
